//--- design/byte_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Depth must be a power of two.
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clear_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wr_q;
  logic [PW:0] rd_q;
  logic push;
  logic pop;

  assign in_ready_out = (wr_q - rd_q) != (PW+1)'(DEPTH);
  assign out_valid_out = wr_q != rd_q;
  assign out_data_out = mem[rd_q[PW-1:0]];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_q[PW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (clear_in) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

//--- design/eeprom_pkg.sv
// Purpose: Shared constants for the two-wire EEPROM slave.
// Assumes: 200 MHz core clock, 256-byte array, 16-byte page.
// Notes: Program time is modelled, not the cell physics.
package eeprom_pkg;
  localparam int ADDR_W = 8;
  localparam int PAGE_W = 4;
  localparam int PAGE_BYTES = 16;
  localparam logic [3:0] TYPE_FIELD = 4'ha;
  localparam int CLK_PERIOD_PS = 5000;
  // Longest internal write time, in microseconds
  localparam int PROG_TIME_US = 5000;
  // Cycles per microsecond first: the product in picoseconds overflows int
  localparam int PROG_CYCLES = PROG_TIME_US * (1000000 / CLK_PERIOD_PS);
  localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;
  localparam int FIFO_DEPTH = 8;
endpackage

//--- design/eeprom_slave.sv
// Purpose: Command, addressing and write-cycle logic of a 256-byte
//   two-wire serial EEPROM slave.
// Assumes: Bus clock well below clk_in/8; pins are open drain.
// Notes: Received write bytes pass through a FIFO into the page buffer.
`timescale 1ns/1ps
// Notes on behaviour
// - Byte write: address(w), word address, one data byte, each acked.
// - STOP ending a write starts the internal programming cycle.
// - While programming, ignore the bus and drive no acknowledge.
// - Page write sends up to 16 bytes programmed in one cycle.
// - Each write byte is acked and bumps only the in-page bits.
// - More than 16 bytes wrap in page, overwriting earlier bytes.
// - After STOP all buffered page bytes commit together.
// - Poll by START plus write address; no ack while busy.
// - After programming ends a polling address is acknowledged.
// - Write-protect high makes the whole array read-only.
// - Protected: ack addresses, refuse first data byte, program nothing.
// - Read starts like write but with read/write bit one.
// - Address counter holds last accessed address plus one.
// - Counter wraps from 255 to zero, data stays valid.
// - Current read: ack address, send byte, master nacks and stops.
// - Repeated START with read returns the byte at loaded address.
// - Each master ack in a read yields the next byte.
// - Reads increment all counter bits across pages.
// - Master nack ends sending; release data and wait for STOP.
// - Respond only to type field 1010; low bit selects read.
// - Supervisory reset aborts transfers but lets programming finish.
module eeprom_slave
  import eeprom_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_n_out,
  input wire logic wp_in,
  input wire logic sup_reset_in,
  output logic busy_out
);
  typedef enum {
    ST_IDLE, ST_DEVADDR, ST_DEVACK, ST_WORD, ST_WORDACK,
    ST_DATA, ST_DATAACK, ST_TXBYTE, ST_TXACK, ST_WAITSTOP
  } bus_state_t;

  // ==========================================================
  // Pin synchronisers and condition detection
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_q;
  logic sda_q;
  logic wp_q;
  logic [1:0] wp_sync_q;
  logic [1:0] rst_sync_q;
  logic sup_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      wp_sync_q <= 2'h0;
      rst_sync_q <= 2'h0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      wp_sync_q <= {wp_sync_q[0], wp_in};
      rst_sync_q <= {rst_sync_q[0], sup_reset_in};
      scl_q <= scl_sync_q[1];
      sda_q <= sda_sync_q[1];
    end
  end

  assign wp_q = wp_sync_q[1];
  assign sup_q = rst_sync_q[1];

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise = scl_sync_q[1] && !scl_q;
  assign scl_fall = !scl_sync_q[1] && scl_q;
  assign start_det = scl_sync_q[1] && scl_q && sda_q && !sda_sync_q[1];
  assign stop_det = scl_sync_q[1] && scl_q && !sda_q && sda_sync_q[1];

  // ==========================================================
  // Array, page buffer and programming timer
  logic [7:0] array_q [2**ADDR_W];
  logic [7:0] page_q [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_vld_q;
  logic [ADDR_W-PAGE_W-1:0] page_base_q;
  logic [31:0] prog_cnt_q;
  logic busy_q;
  logic commit;

  // Write bytes tagged with their in-page slot travel through the FIFO
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [PAGE_W+7:0] fifo_in_data;
  logic fifo_out_valid;
  logic [PAGE_W+7:0] fifo_out_data;
  logic fifo_clear;

  byte_fifo #(.WIDTH(PAGE_W + 8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .clear_in(fifo_clear),
    .in_valid_in(fifo_in_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(fifo_in_data),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(1'b1),
    .out_data_out(fifo_out_data)
  );

  always_ff @(posedge clk_in) begin
    if (fifo_out_valid) begin
      page_q[fifo_out_data[PAGE_W+7:8]] <= fifo_out_data[7:0];
    end
    if (commit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (page_vld_q[i]) begin
          array_q[{page_base_q, PAGE_W'(i)}] <= page_q[i];
        end
      end
    end
  end

  // ==========================================================
  // Bus state machine
  bus_state_t state_q;
  logic [7:0] shift_q;
  logic [3:0] bit_q;
  logic rd_q;
  logic wr_seen_q;
  logic first_q;
  logic ack_q;
  logic [ADDR_W-1:0] ctr_q;
  logic [PAGE_W-1:0] slot_q;
  logic sda_drive_q;

  function automatic logic [ADDR_W-1:0] page_inc(
    input logic [ADDR_W-1:0] a
  );
    page_inc = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 1'b1};
  endfunction

  assign commit = stop_det && wr_seen_q && !busy_q && !sup_q &&
                  (state_q != ST_IDLE) && !fifo_out_valid;
  // Bytes of a transfer cut by supervisory reset must never reach the page
  assign fifo_clear = sup_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_q <= 1'b0;
      prog_cnt_q <= '0;
    end else if (commit) begin
      busy_q <= 1'b1;
      prog_cnt_q <= 32'(PROG_CYC);
    end else if (busy_q) begin
      // Keeps counting under supervisory reset: a started cycle finishes
      if (prog_cnt_q == 32'h1) begin
        busy_q <= 1'b0;
      end
      prog_cnt_q <= prog_cnt_q - 32'h1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= ST_IDLE;
      shift_q <= 8'h00;
      bit_q <= 4'h0;
      rd_q <= 1'b0;
      wr_seen_q <= 1'b0;
      first_q <= 1'b0;
      ack_q <= 1'b0;
      ctr_q <= ADDR_RESET;
      slot_q <= '0;
      page_base_q <= '0;
      page_vld_q <= '0;
      fifo_in_valid <= 1'b0;
      fifo_in_data <= '0;
      sda_drive_q <= 1'b0;
    end else begin
      fifo_in_valid <= 1'b0;
      if (sup_q || busy_q) begin
        state_q <= ST_IDLE;
        sda_drive_q <= 1'b0;
        if (!busy_q) begin
          wr_seen_q <= 1'b0;
        end
      end else if (stop_det) begin
        state_q <= ST_IDLE;
        sda_drive_q <= 1'b0;
        wr_seen_q <= 1'b0;
      end else if (start_det) begin
        state_q <= ST_DEVADDR;
        bit_q <= 4'h0;
        sda_drive_q <= 1'b0;
        page_vld_q <= wr_seen_q ? page_vld_q : '0;
      end else begin
        case (state_q)
          ST_DEVADDR, ST_WORD, ST_DATA: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_q};
              bit_q <= bit_q + 4'h1;
            end else if (scl_fall && bit_q == 4'h8) begin
              bit_q <= 4'h0;
              if (state_q == ST_DEVADDR) begin
                ack_q <= shift_q[7:4] == TYPE_FIELD;
                rd_q <= shift_q[0];
                sda_drive_q <= shift_q[7:4] == TYPE_FIELD;
                state_q <= shift_q[7:4] == TYPE_FIELD ? ST_DEVACK
                                                     : ST_WAITSTOP;
              end else if (state_q == ST_WORD) begin
                ctr_q <= shift_q;
                page_base_q <= shift_q[7:PAGE_W];
                slot_q <= shift_q[PAGE_W-1:0];
                first_q <= 1'b1;
                sda_drive_q <= 1'b1;
                state_q <= ST_WORDACK;
              end else if (wp_q) begin
                sda_drive_q <= 1'b0;
                state_q <= ST_WAITSTOP;
              end else begin
                fifo_in_valid <= fifo_in_ready;
                fifo_in_data <= {slot_q, shift_q};
                page_vld_q[slot_q] <= 1'b1;
                slot_q <= slot_q + 1'b1;
                ctr_q <= page_inc(ctr_q);
                wr_seen_q <= 1'b1;
                sda_drive_q <= 1'b1;
                state_q <= ST_DATAACK;
              end
            end
          end
          ST_DEVACK, ST_WORDACK, ST_DATAACK: begin
            if (scl_fall) begin
              if (state_q == ST_DEVACK && rd_q) begin
                shift_q <= array_q[ctr_q];
                sda_drive_q <= !array_q[ctr_q][7];
                ctr_q <= ctr_q + 1'b1;
                state_q <= ST_TXBYTE;
              end else begin
                sda_drive_q <= 1'b0;
                state_q <= state_q == ST_DEVACK ? ST_WORD : ST_DATA;
              end
            end
          end
          ST_TXBYTE: begin
            if (scl_fall) begin
              bit_q <= bit_q + 4'h1;
              if (bit_q == 4'h7) begin
                sda_drive_q <= 1'b0;
                bit_q <= 4'h0;
                state_q <= ST_TXACK;
              end else begin
                shift_q <= {shift_q[6:0], 1'b0};
                sda_drive_q <= !shift_q[6];
              end
            end
          end
          ST_TXACK: begin
            if (scl_rise) begin
              ack_q <= !sda_q;
            end else if (scl_fall) begin
              if (ack_q) begin
                shift_q <= array_q[ctr_q];
                sda_drive_q <= !array_q[ctr_q][7];
                ctr_q <= ctr_q + 1'b1;
                state_q <= ST_TXBYTE;
              end else begin
                state_q <= ST_WAITSTOP;
              end
            end
          end
          default: begin
            sda_drive_q <= 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sda_oe_n_out <= 1'b1;
      busy_out <= 1'b0;
    end else begin
      sda_oe_n_out <= !sda_drive_q;
      busy_out <= busy_q;
    end
  end

  // ==========================================================
  // Checks
  chk_busy_no_drive: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    busy_q |=> ##1 sda_oe_n_out)
    else $error("Data line driven while programming");

  chk_commit_busy: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    commit |=> busy_q && prog_cnt_q == 32'(PROG_CYC))
    else $error("Programming did not start on stop");

  chk_wp_no_commit: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    wp_q && state_q == ST_DATA |-> !fifo_in_valid ##1 !fifo_in_valid)
    else $error("Write accepted while protected");

  chk_page_bits_hold: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    state_q == ST_DATAACK && $past(state_q) == ST_DATA |->
      ctr_q[7:4] == $past(ctr_q[7:4]))
    else $error("Page bits changed during write");

  chk_read_inc: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    state_q == ST_TXBYTE && $past(state_q) != ST_TXBYTE |->
      ctr_q == $past(ctr_q) + 8'h01)
    else $error("Read counter not advanced");

  chk_nack_release: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    state_q == ST_TXACK && scl_fall && !ack_q |=>
      state_q == ST_WAITSTOP ##1 sda_oe_n_out)
    else $error("Line held after master nack");

  chk_type_filter: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    state_q == ST_DEVACK |-> shift_q[7:4] == TYPE_FIELD)
    else $error("Acked a foreign type field");

  chk_sup_abort: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    sup_q |=> state_q == ST_IDLE && !commit)
    else $error("Transfer survived supervisory reset");
endmodule

//--- verification/bus_master.sv
// Purpose: Two-wire bus master that clocks the EEPROM slave.
// Assumes: Bus clock low 13 and high 12 core cycles, 125 ns.
// Notes: A released line floats high through the bench pull-up.
`timescale 1ns/1ps
module bus_master (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_n_out
);
  // ==========================================
  // Bus phases, all moved on core falling edges
  initial begin
    scl_out = 1'b1;
    sda_oe_n_out = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // Also serves as repeated start
  task automatic start();
    sda_oe_n_out = 1'b1;
    hold(6);
    scl_out = 1'b1;
    hold(6);
    sda_oe_n_out = 1'b0;
    hold(6);
    scl_out = 1'b0;
    hold(7);
  endtask
  task automatic stop();
    sda_oe_n_out = 1'b0;
    hold(6);
    scl_out = 1'b1;
    hold(6);
    sda_oe_n_out = 1'b1;
    hold(12);
  endtask
  // Data moves only while the clock is low, sampled mid-high
  task automatic xfer(input logic b, output logic r);
    sda_oe_n_out = b;
    hold(7);
    scl_out = 1'b1;
    hold(6);
    r = sda_in;
    hold(6);
    scl_out = 1'b0;
    hold(6);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(d[i], r);
    end
    xfer(1'b1, ack_n);
  endtask
  task automatic rd_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b1, d[i]);
    end
    xfer(~more, r);
  endtask
endmodule

//--- verification/tb.sv
// Purpose: Self-checking bench for the EEPROM slave.
// Assumes: Short programming time; bench tracks memory contents.
// Notes: Only bytes written by the bench are ever read back.
`timescale 1ns/1ps
module tb;
  import eeprom_pkg::*;
  // Longer than one poll so a poll surely meets a busy device
  localparam int PROG = 600;
  logic clk_in, rst_n_in, wp_in, sup_reset_in;
  logic scl, m_oe_n, d_oe_n, busy_out, ack_n;
  wire sda = m_oe_n & d_oe_n;
  int mismatches = 0;
  int checked = 0;
  logic [7:0] cnt, d;
  logic [7:0] mem [256];
  eeprom_slave #(.PROG_CYC(PROG)) eeprom_slave_inst (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda),
    .sda_oe_n_out(d_oe_n), .wp_in(wp_in), .sup_reset_in(sup_reset_in),
    .busy_out(busy_out));
  bus_master bus_master_inst (.clk_in(clk_in), .sda_in(sda),
    .scl_out(scl), .sda_oe_n_out(m_oe_n));
  // ==========================================
  // Clock, timeout and verdict
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial begin
    repeat (60000) @(posedge clk_in);
    mismatches++;
    $display("mismatch at %0t: timeout", $time);
    finish_test();
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // ==========================================
  // Transfer helpers
  task automatic put(input logic [7:0] b, input logic exp_n);
    bus_master_inst.wr_byte(b, ack_n);
    check(8'(ack_n), 8'(exp_n));
  endtask
  task automatic write(input logic [7:0] wa, input int n,
                       input logic [7:0] base);
    bus_master_inst.start();
    put(8'ha0, 1'b0);
    put(wa, 1'b0);
    for (int i = 0; i < n; i++) begin
      put(base + 8'(i), wp_in);
      if (!wp_in) mem[{wa[7:4], 4'(wa[3:0] + i)}] = base + 8'(i);
    end
    bus_master_inst.stop();
    cnt = {wa[7:4], 4'(wa[3:0] + (wp_in ? 0 : n))};
  endtask
  task automatic wait_idle();
    for (int k = 0; k < PROG + 20 && busy_out === 1'b1; k++) begin
      @(negedge clk_in);
    end
    check(8'(busy_out), 8'h00);
  endtask
  task automatic settle();
    for (int k = 0; k < 20 && busy_out !== 1'b1; k++) begin
      @(negedge clk_in);
    end
    check(8'(busy_out), 8'h01);
    bus_master_inst.start();
    put(8'ha0, 1'b1);
    bus_master_inst.stop();
    wait_idle();
    bus_master_inst.start();
    put(8'ha0, 1'b0);
    bus_master_inst.stop();
  endtask
  task automatic read(input logic rnd, input logic [7:0] wa, input int n);
    logic [7:0] ptr;
    ptr = rnd ? wa : cnt;
    if (rnd) begin
      bus_master_inst.start();
      put(8'ha0, 1'b0);
      put(wa, 1'b0);
    end
    bus_master_inst.start();
    put(8'ha1, 1'b0);
    for (int i = 0; i < n; i++) begin
      bus_master_inst.rd_byte(i < n - 1, d);
      check(d, mem[ptr]);
      ptr++;
    end
    bus_master_inst.stop();
    cnt = ptr;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_byte();
    write(8'h10, 1, 8'h5a);
    settle();
    read(1'b1, 8'h10, 1);
    $display("done byte write and random read");
  endtask
  task automatic t_page();
    write(8'h3e, 18, 8'h80);
    settle();
    read(1'b0, 8'h00, 1);
    write(8'h40, 1, 8'hc4);
    settle();
    read(1'b1, 8'h3f, 2);
    $display("done page wrap and cross-page read");
  endtask
  task automatic t_wrap();
    write(8'hff, 1, 8'he1);
    settle();
    write(8'h00, 1, 8'h0e);
    settle();
    read(1'b1, 8'hff, 2);
    $display("done array wrap read");
  endtask
  task automatic t_protect();
    wp_in = 1'b1;
    write(8'h10, 1, 8'h00);
    bus_master_inst.hold(50);
    check(8'(busy_out), 8'h00);
    wp_in = 1'b0;
    read(1'b1, 8'h10, 1);
    $display("done write protect");
  endtask
  task automatic t_type();
    logic [7:0] bad [3] = '{8'h20, 8'hb0, 8'he1};
    foreach (bad[i]) begin
      bus_master_inst.start();
      put(bad[i], 1'b1);
      bus_master_inst.stop();
    end
    $display("done foreign addresses");
  endtask
  task automatic t_sup();
    write(8'h20, 1, 8'h77);
    sup_reset_in = 1'b1;
    bus_master_inst.start();
    put(8'ha1, 1'b1);
    bus_master_inst.stop();
    check(8'(busy_out), 8'h01);
    wait_idle();
    // Programming is over here, so only the supervisory reset refuses
    bus_master_inst.start();
    put(8'ha0, 1'b1);
    bus_master_inst.stop();
    sup_reset_in = 1'b0;
    bus_master_inst.hold(10);
    read(1'b1, 8'h20, 1);
    // A write cut by the supervisory reset must program nothing
    bus_master_inst.start();
    put(8'ha0, 1'b0);
    put(8'h20, 1'b0);
    sup_reset_in = 1'b1;
    put(8'h99, 1'b1);
    bus_master_inst.stop();
    bus_master_inst.hold(20);
    check(8'(busy_out), 8'h00);
    sup_reset_in = 1'b0;
    bus_master_inst.hold(10);
    read(1'b1, 8'h20, 1);
    $display("done supervisory reset");
  endtask
  initial begin
    rst_n_in = 1'b0;
    wp_in = 1'b0;
    sup_reset_in = 1'b0;
    repeat (16) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    t_byte();
    t_page();
    t_wrap();
    t_protect();
    t_type();
    t_sup();
    finish_test();
  end
endmodule
